// ==== err_route_pkg.sv ====
// Constants shared by the internal error routing block
package err_route_pkg;

  // Bus geometry
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 32;
  localparam int          FLAG_W       = 8;

  // Register indices as printed; the byte address is four times the index
  localparam logic [9:0]  ERR0_IDX     = 10'h0d0;
  localparam logic [9:0]  MC_IDX       = 10'h0d3;
  localparam logic [11:0] ERR0_ADDR    = {ERR0_IDX, 2'b00};
  localparam logic [11:0] MC_ADDR      = {MC_IDX, 2'b00};

  // Block-local registers: flags, interrupt mask, indication status
  localparam logic [11:0] FLAG_ADDR    = 12'h000;
  localparam logic [11:0] IMASK_ADDR   = 12'h004;
  localparam logic [11:0] OSTAT_ADDR   = 12'h008;

  // Flag positions, shared by the flag, mask and routing registers
  localparam int          BIT_INV_LINE = 7;
  localparam int          BIT_SNP_MECC = 6;
  localparam int          BIT_SNP_SECC = 5;
  localparam int          BIT_ADDRMAP  = 4;
  localparam int          BIT_VPIN     = 3;
  localparam int          BIT_WB_VIOL  = 2;
  localparam int          BIT_MULTHIT  = 1;
  localparam int          BIT_DIR_PAR  = 0;

  // Indication status register fields
  localparam int          OST_ERR0     = 0;
  localparam int          OST_MC       = 1;
  localparam int          OST_IRQ      = 2;

  // Reset values
  localparam logic [7:0]  ROUTE_RESET  = 8'hff;
  localparam logic [7:0]  FLAG_RESET   = 8'h00;
  localparam logic [7:0]  IMASK_RESET  = 8'h00;

  // AXI response codes
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

endpackage

// ==== err_route.sv ====
// Internal error flag routing to error output zero and machine check
//
// Behaviour
// - Error output zero is high while a set flag is let through its routing bit.
// - Machine check is high while a set flag is let through its routing bit.
// - Bit 7 routes the snoop filter coherency error on invalidate line.
// - Bit 6 routes the multi-bit snoop filter lookup ECC error.
// - Bit 5 routes the single-bit snoop filter lookup ECC error.
// - Bit 4 routes the coherency logic address map error.
// - Bit 3 routes the sideband virtual pin port error.
// - Bit 2 routes the explicit writeback coherency violation.
// - Bit 1 routes the snoop filter multiple tag hit.
// - Bit 0 routes the directory storage parity error.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module err_route
  import err_route_pkg::*;
(
  // Clock and resets
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              poweron_resetn,
  // Error events from the coherency, snoop filter and sideband logic
  input  wire logic              inval_line_err,
  input  wire logic              snoop_mecc_err,
  input  wire logic              snoop_secc_err,
  input  wire logic              addrmap_err,
  input  wire logic              vpin_err,
  input  wire logic              wb_viol_err,
  input  wire logic              multi_hit_err,
  input  wire logic              dir_parity_err,
  // Outgoing indications
  output logic                   error_zero_out,
  output logic                   machine_check_indication,
  output logic                   irq,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  // AXI4-Lite write data
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);

  // Decode of the mapped word addresses, shared by reads and writes
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == FLAG_ADDR) || (a == IMASK_ADDR) || (a == OSTAT_ADDR) ||
                (a == ERR0_ADDR) || (a == MC_ADDR);
  endfunction

  // Registers
  logic [FLAG_W-1:0] flag_reg;
  logic [FLAG_W-1:0] imask_reg;
  logic [FLAG_W-1:0] err0_route_reg;
  logic [FLAG_W-1:0] mc_route_reg;
  logic              err0_out_reg;
  logic              mc_out_reg;
  logic              irq_reg;
  // Bus state
  logic              aw_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              w_full_reg;
  logic [7:0]        w_data_reg;
  logic              w_strb_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0]        rresp_reg;

  // Event vector laid out in the routing register bit order
  logic [FLAG_W-1:0] event_vec;
  assign event_vec[BIT_INV_LINE] = inval_line_err;
  assign event_vec[BIT_SNP_MECC] = snoop_mecc_err;
  assign event_vec[BIT_SNP_SECC] = snoop_secc_err;
  assign event_vec[BIT_ADDRMAP]  = addrmap_err;
  assign event_vec[BIT_VPIN]     = vpin_err;
  assign event_vec[BIT_WB_VIOL]  = wb_viol_err;
  assign event_vec[BIT_MULTHIT]  = multi_hit_err;
  assign event_vec[BIT_DIR_PAR]  = dir_parity_err;

  // Channel handshakes
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_do;
  assign aw_take = awvalid & awready_reg;
  assign w_take  = wvalid & wready_reg;
  assign ar_take = arvalid & arready_reg;
  // Commit only once both halves are held and the last response is gone
  assign wr_do   = aw_full_reg & w_full_reg & ~bvalid_reg;

  // Write decode; only the low byte lane carries register bits
  logic wr_lane;
  logic wr_flag;
  logic wr_imask;
  logic wr_err0;
  logic wr_mc;
  assign wr_lane  = wr_do & w_strb_reg;
  assign wr_flag  = wr_lane & (aw_addr_reg == FLAG_ADDR);
  assign wr_imask = wr_lane & (aw_addr_reg == IMASK_ADDR);
  assign wr_err0  = wr_lane & (aw_addr_reg == ERR0_ADDR);
  assign wr_mc    = wr_lane & (aw_addr_reg == MC_ADDR);
  // Response code is fixed by the held address alone
  logic [1:0] wr_resp;
  assign wr_resp  = is_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;

  // Flags: write one to clear, a new event beats a clear in the same cycle
  logic [FLAG_W-1:0] flag_clr;
  logic [FLAG_W-1:0] flag_next;
  assign flag_clr  = wr_flag ? w_data_reg : 8'h00;
  assign flag_next = (flag_reg & ~flag_clr) | event_vec;

  // Routing: a one blocks, so indications use the inverted enables
  logic [FLAG_W-1:0] err0_route_next;
  logic [FLAG_W-1:0] mc_route_next;
  logic              err0_next;
  logic              mc_next;
  logic              irq_next;
  // Power-up reset drives the blocked pattern into the indications at once
  logic              route_init;
  assign route_init      = ~poweron_resetn;
  assign err0_route_next = route_init ? ROUTE_RESET :
                           wr_err0    ? w_data_reg : err0_route_reg;
  assign mc_route_next   = route_init ? ROUTE_RESET :
                           wr_mc      ? w_data_reg : mc_route_reg;
  assign err0_next = |(flag_next & ~err0_route_next);
  assign mc_next   = |(flag_next & ~mc_route_next);
  // Mask change reaches irq at its commit edge, as routing does
  logic [FLAG_W-1:0] imask_next;
  assign imask_next = wr_imask ? w_data_reg : imask_reg;
  // No check for a flag routed twice; overlap is left to software
  assign irq_next  = |(flag_next & imask_next);

  // Write channel next state
  logic aw_full_next;
  logic w_full_next;
  logic bvalid_next;
  assign aw_full_next = (aw_full_reg | aw_take) & ~wr_do;
  assign w_full_next  = (w_full_reg | w_take) & ~wr_do;
  assign bvalid_next  = wr_do | (bvalid_reg & ~bready);
  // A ready stays low while its half of the write is held
  logic awready_next;
  logic wready_next;
  assign awready_next = ~aw_full_next;
  assign wready_next  = ~w_full_next;

  // Read channel next state
  logic              rvalid_next;
  logic              arready_next;
  assign rvalid_next  = ar_take | (rvalid_reg & ~rready);
  assign arready_next = ~rvalid_next;

  // Read decode; the byte offset bits are ignored as on writes
  logic [ADDR_W-1:0] ar_word;
  logic              rd_flag;
  logic              rd_imask;
  logic              rd_ostat;
  logic              rd_err0;
  logic              rd_mc;
  logic [1:0]        rd_resp;
  assign ar_word  = {araddr[ADDR_W-1:2], 2'b00};
  assign rd_flag  = (ar_word == FLAG_ADDR);
  assign rd_imask = (ar_word == IMASK_ADDR);
  assign rd_ostat = (ar_word == OSTAT_ADDR);
  assign rd_err0  = (ar_word == ERR0_ADDR);
  assign rd_mc    = (ar_word == MC_ADDR);
  assign rd_resp  = is_mapped(ar_word) ? RESP_OKAY : RESP_SLVERR;

  // Indication status word
  logic [FLAG_W-1:0] ostat;
  assign ostat[OST_ERR0]           = err0_out_reg;
  assign ostat[OST_MC]             = mc_out_reg;
  assign ostat[OST_IRQ]            = irq_reg;
  assign ostat[FLAG_W-1:OST_IRQ+1] = 5'h00;

  // Register bits sit in the low byte; unmapped words and upper bytes read zero
  logic [FLAG_W-1:0] rd_byte;
  logic [DATA_W-1:0] rd_mux;
  assign rd_byte = rd_flag  ? flag_reg :
                   rd_imask ? imask_reg :
                   rd_ostat ? ostat :
                   rd_err0  ? err0_route_reg :
                   rd_mc    ? mc_route_reg :
                   8'h00;
  assign rd_mux  = {24'h000000, rd_byte};

  // Sticky routing registers, untouched by the warm reset
  always_ff @(posedge aclk) begin
    if (!poweron_resetn) begin
      err0_route_reg <= ROUTE_RESET;
      mc_route_reg   <= ROUTE_RESET;
    end else begin
      err0_route_reg <= err0_route_next;
      mc_route_reg   <= mc_route_next;
    end
  end

  // Flags, interrupt mask and registered indications
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg     <= FLAG_RESET;
      imask_reg    <= IMASK_RESET;
      err0_out_reg <= 1'b0;
      mc_out_reg   <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      flag_reg     <= flag_next;
      imask_reg    <= imask_next;
      err0_out_reg <= err0_next;
      mc_out_reg   <= mc_next;
      irq_reg      <= irq_next;
    end
  end

  // Write address and data holding; either may arrive first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      if (aw_take) begin
        aw_addr_reg <= {awaddr[ADDR_W-1:2], 2'b00};
      end
      if (w_take) begin
        w_data_reg <= wdata[7:0];
        w_strb_reg <= wstrb[0];
      end
    end
  end

  // Write response; unmapped addresses answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else begin
      bvalid_reg <= bvalid_next;
      if (wr_do) begin
        bresp_reg <= wr_resp;
      end
    end
  end

  // Read path; the address is sampled once, so one read is in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_mux;
        rresp_reg <= rd_resp;
      end
    end
  end

  // Ports straight from flops
  assign error_zero_out           = err0_out_reg;
  assign machine_check_indication = mc_out_reg;
  assign irq                      = irq_reg;
  assign awready                  = awready_reg;
  assign wready                   = wready_reg;
  assign bvalid                   = bvalid_reg;
  assign bresp                    = bresp_reg;
  assign arready                  = arready_reg;
  assign rvalid                   = rvalid_reg;
  assign rdata                    = rdata_reg;
  assign rresp                    = rresp_reg;

endmodule // err_route

// ==== err_route_sva.sv ====
// Port assertions for the internal error routing block
`timescale 1ns/1ns
module err_route_chk (
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic poweron_resetn,
  // Error events
  input wire logic inval_line_err,
  input wire logic snoop_mecc_err,
  input wire logic snoop_secc_err,
  input wire logic addrmap_err,
  input wire logic vpin_err,
  input wire logic wb_viol_err,
  input wire logic multi_hit_err,
  input wire logic dir_parity_err,
  // Indications
  input wire logic error_zero_out,
  input wire logic machine_check_indication,
  input wire logic irq,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid
);
  // Any event seen at an edge
  wire logic ev = inval_line_err | snoop_mecc_err | snoop_secc_err | addrmap_err | vpin_err
                  | wb_viol_err | multi_hit_err | dir_parity_err;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Indications move only on an event, a commit or a power-up reset
  err0_rise_a: assert property ($rose(error_zero_out) |-> $past(ev) || $rose(bvalid))
    else $error("error zero rose without cause");
  mc_rise_a: assert property ($rose(machine_check_indication) |-> $past(ev) || $rose(bvalid))
    else $error("machine check rose without cause");
  irq_rise_a: assert property ($rose(irq) |-> $past(ev) || $rose(bvalid))
    else $error("irq rose without cause");
  err0_fall_a: assert property ($fell(error_zero_out) |-> $rose(bvalid) || $past(!poweron_resetn))
    else $error("error zero fell without cause");
  mc_fall_a: assert property ($fell(machine_check_indication) |-> $rose(bvalid) || $past(!poweron_resetn))
    else $error("machine check fell without cause");
  // Power-up reset blocks every flag from both indications
  por_block_a: assert property (!poweron_resetn |=> !error_zero_out && !machine_check_indication)
    else $error("indication high after power-up reset");
  wr_resp_a: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##1 !bvalid ##1 bvalid)
    else $error("write response late");
  rd_resp_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read response late");
  cover property ($rose(error_zero_out));
  cover property ($rose(machine_check_indication));
  cover property ($rose(irq));
endmodule // err_route_chk

bind err_route err_route_chk i_err_route_chk (.aclk, .aresetn, .poweron_resetn, .inval_line_err,
  .snoop_mecc_err, .snoop_secc_err, .addrmap_err, .vpin_err, .wb_viol_err, .multi_hit_err,
  .dir_parity_err, .error_zero_out, .machine_check_indication, .irq, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid);

// ==== err_sink.sv ====
// Model of the system error handler and processor check input
`timescale 1ns/1ns
module err_sink (
  // Clock
  input  wire logic aclk,
  // Indications from the block
  input  wire logic err0,
  input  wire logic mc,
  // Reports taken so far
  output int        n0,
  output int        nmc
);
  logic err0_reg = 1'b0;
  logic mc_reg   = 1'b0;
  int   n0_reg   = 0;
  int   nmc_reg  = 0;
  // A held level is one report, so only rising edges count
  always @(posedge aclk) begin
    err0_reg <= err0;
    mc_reg   <= mc;
    n0_reg   <= n0_reg + int'(err0 & !err0_reg);
    nmc_reg  <= nmc_reg + int'(mc & !mc_reg);
  end
  // Counts handed to the bench, one driver each
  assign n0  = n0_reg;
  assign nmc = nmc_reg;
endmodule // err_sink

// ==== test_internal_error_signal_routing.sv ====
// Bench for the internal error routing block
`timescale 1ns/1ns
module test_internal_error_signal_routing
  import err_route_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, poweron_resetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
  logic [7:0]  ev = 8'h00;
  logic [3:0]  wstrb = 4'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  wire logic   awready, wready, bvalid, arready, rvalid;
  wire logic   error_zero_out, machine_check_indication, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          err_total = 0, total_checks = 0, n0, nmc;

  err_route i_err_route (.aclk, .aresetn, .poweron_resetn, .inval_line_err(ev[7]),
    .snoop_mecc_err(ev[6]), .snoop_secc_err(ev[5]), .addrmap_err(ev[4]), .vpin_err(ev[3]),
    .wb_viol_err(ev[2]), .multi_hit_err(ev[1]), .dir_parity_err(ev[0]), .error_zero_out,
    .machine_check_indication, .irq, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  err_sink i_err_sink (.aclk, .err0(error_zero_out), .mc(machine_check_indication), .n0, .nmc);

  always #10 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bus write; each channel drops once taken, only the watchdog ends the wait
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, r});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, r});
    chk(rdata, d);
  endtask

  // One-cycle event burst, then the three indication ports
  task automatic pulse(input logic [7:0] m, input logic [2:0] e);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 8'h00;
    @(posedge aclk);
    chk({29'h0, error_zero_out, machine_check_indication, irq}, {29'h0, e});
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    poweron_resetn <= 1'b1;
    rd(ERR0_ADDR, 32'hff, RESP_OKAY);
    rd(MC_ADDR, 32'hff, RESP_OKAY);
    rd(12'h100, 32'h0, RESP_SLVERR);
    wr(12'h100, 32'h0, 4'hf, RESP_SLVERR);
    pulse(8'hff, 3'b000);
    wr(FLAG_ADDR, 32'hff, 4'hf, RESP_OKAY);
    // Each flag on exactly one indication, walked over all eight positions
    for (int i = 0; i < 8; i++) begin
      wr(ERR0_ADDR, {24'h0, ~(8'h01 << i)}, 4'hf, RESP_OKAY);
      wr(MC_ADDR, {24'h0, ~(8'h80 >> i)}, 4'hf, RESP_OKAY);
      pulse(8'h01 << i, 3'b100);
      rd(FLAG_ADDR, {24'h0, 8'h01 << i}, RESP_OKAY);
      wr(FLAG_ADDR, 32'hff, 4'hf, RESP_OKAY);
      pulse(8'h80 >> i, 3'b010);
      wr(FLAG_ADDR, 32'hff, 4'hf, RESP_OKAY);
      pulse(~((8'h01 << i) | (8'h80 >> i)), 3'b000);
      wr(FLAG_ADDR, 32'hff, 4'hf, RESP_OKAY);
    end
    chk(32'(n0), 32'd8);
    chk(32'(nmc), 32'd8);
    wr(ERR0_ADDR, 32'h0, 4'h0, RESP_OKAY);
    rd(ERR0_ADDR, 32'h7f, RESP_OKAY);
    // Interrupt raised, masked, then cleared
    wr(IMASK_ADDR, 32'h08, 4'hf, RESP_OKAY);
    pulse(8'h08, 3'b001);
    wr(IMASK_ADDR, 32'h0, 4'hf, RESP_OKAY);
    rd(OSTAT_ADDR, 32'h0, RESP_OKAY);
    wr(FLAG_ADDR, 32'hff, 4'hf, RESP_OKAY);
    rd(FLAG_ADDR, 32'h0, RESP_OKAY);
    // Warm reset keeps routing, power-up reset restores it
    wr(ERR0_ADDR, 32'hffffff5a, 4'hf, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ERR0_ADDR, 32'h5a, RESP_OKAY);
    // Both indications high, then power-up reset must block them with the flag kept
    pulse(8'h01, 3'b110);
    poweron_resetn <= 1'b0;
    repeat (2) @(posedge aclk);
    poweron_resetn <= 1'b1;
    rd(OSTAT_ADDR, 32'h0, RESP_OKAY);
    rd(FLAG_ADDR, 32'h01, RESP_OKAY);
    rd(ERR0_ADDR, 32'hff, RESP_OKAY);
    rd(MC_ADDR, 32'hff, RESP_OKAY);
    summarize();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #400000;
    err_total++;
    summarize();
  end
endmodule // test_internal_error_signal_routing
